// ### pkg/iox_defines.svh
// register offsets, reset values and counts of the expander core
`ifndef IOX_DEFINES_SVH
`define IOX_DEFINES_SVH

// byte offsets on the register bus
`define IOX_OFF_IN0 6'h00
`define IOX_OFF_IN1 6'h04
`define IOX_OFF_OUT0 6'h08
`define IOX_OFF_OUT1 6'h0c
`define IOX_OFF_POL0 6'h10
`define IOX_OFF_POL1 6'h14
`define IOX_OFF_DIR0 6'h18
`define IOX_OFF_DIR1 6'h1c
`define IOX_OFF_BUSADR 6'h20
`define IOX_OFF_STAT 6'h24
`define IOX_OFF_MASK 6'h28

// reset values; a direction bit of one means input
`define IOX_RST_OUT 8'hff
`define IOX_RST_POL 8'h00
`define IOX_RST_DIR 8'hff
`define IOX_RST_MASK 2'h0

// upper six bits of the serial bus address, arbitrary value
`define IOX_BUS_ADDR_BASE 6'h10

// cycles after reset during which the input registers follow the pins;
// one more than the three synchroniser stages plus the filter, so the last capture sees filtered pins
`define IOX_SETTLE_CYCLES 3'd5

// status bit positions
`define IOX_STAT_LOW 0
`define IOX_STAT_HIGH 1

`endif

// ### pkg/iox_pkg.sv
// types shared by the expander core
package iox_pkg;
  typedef enum logic [1:0] {
    IOX_RESP_OKAY = 2'h0,
    IOX_RESP_SLVERR = 2'h2
  } iox_resp_t;
endpackage : iox_pkg

// ### verilog/iox_core.sv
// sixteen-bit i/o expander core with an axi4-lite register slave
// Functional notes
// [R01] eight 8-bit registers: direction, input, output, polarity, one per half
// [R02] each pin is input or output per its direction bit, set by writes
// [R03] after any reset all sixteen pins are inputs
// [R04] input register holds sensed level, output register the driven level
// [R05] a set polarity bit inverts the pin level seen in the input register
// [R06] all eight registers are readable over the bus
// [R07] alert pulled low while any input differs from its input register bit
// [R08] external reset pin low resets everything like power-on
// [R09] address-select pin sets the low bit of the serial bus address
// [R10] a read of the input register returns the current port data
// [R11] alert clears when data returns or when the input register is read
// [R12] output pins never alert; other traffic leaves the alert alone (here a polarity or direction write can raise it)
// [R13] registers held at defaults while the reset pin stays low
// [R14] port pins are synchronised before comparison
// [R15] on leaving reset input registers capture current pins, others take defaults
`timescale 1ns/10ps
`include "iox_defines.svh"

module iox_core #(
  parameter int ADDR_W = 8
) (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic RESET_N_PIN,
  input wire logic ADDR_SEL_PIN,
  input wire logic [7:0] PORT_LOW_HALF_PINS_IN,
  output logic [7:0] PORT_LOW_HALF_PINS_OUT,
  output logic [7:0] PORT_LOW_HALF_PINS_OE,
  input wire logic [7:0] PORT_HIGH_HALF_PINS_IN,
  output logic [7:0] PORT_HIGH_HALF_PINS_OUT,
  output logic [7:0] PORT_HIGH_HALF_PINS_OE,
  output logic ALERT_N_OUT,
  output logic ALERT_N_OE,
  output logic IRQ,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output iox_pkg::iox_resp_t S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output iox_pkg::iox_resp_t S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  import iox_pkg::*;

  // the decode needs six offset bits; narrower buses cannot be served
  if (ADDR_W < 6) begin : g_addr_w_check
    $error("ADDR_W must be at least 6");
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset

  logic [2:0] rst_pipe;
  logic ext_low;
  logic rst;

  // reset pin sync is cleared only by SRST, never by the reset it produces
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      rst_pipe <= 3'b111;
    end else begin
      rst_pipe <= {rst_pipe[1:0], RESET_N_PIN};
    end
  end

  // pin counts as low once second and third stages agree
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ext_low <= 1'b0;
    end else if (rst_pipe[1] == rst_pipe[2]) begin
      ext_low <= ~rst_pipe[2]; // [R08]
    end
  end

  assign rst = SRST | ext_low; // [R13]

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [16:0] pin_s1;
  logic [16:0] pin_s2;
  logic [16:0] pin_s3;
  logic [16:0] pin_f;
  logic [16:0] agree;

  // three stages; stage one feeds only stage two
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      pin_s1 <= 17'h00000;
      pin_s2 <= 17'h00000;
      pin_s3 <= 17'h00000;
    end else begin
      pin_s1 <= {ADDR_SEL_PIN, PORT_HIGH_HALF_PINS_IN, PORT_LOW_HALF_PINS_IN}; // [R14]
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  assign agree = ~(pin_s2 ^ pin_s3);

  // a bit changes only when the last two stages agree
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      pin_f <= 17'h00000;
    end else begin
      pin_f <= (pin_s3 & agree) | (pin_f & ~agree); // [R14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [15:0] out_reg; // [R01]
  logic [15:0] pol;
  logic [15:0] dir;
  logic [15:0] in_reg;
  logic [1:0] stat;
  logic [1:0] mask;
  logic [2:0] settle;
  logic [15:0] live;
  logic [15:0] diff;
  logic [1:0] ev;
  logic [6:0] bus_addr;

  assign live = pin_f[15:0] ^ pol; // [R05]
  assign bus_addr = {`IOX_BUS_ADDR_BASE, pin_f[16]}; // [R09]

  // only inputs may alert, and not until the synchronisers have filled
  assign diff = dir & (live ^ in_reg) & {16{settle == 3'd0}}; // [R07] [R12]
  assign ev = {|diff[15:8], |diff[7:0]};

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel

  logic aw_hold;
  logic w_hold;
  logic [5:0] aw_off;
  logic aw_hi;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic bvalid;
  iox_resp_t bresp;
  logic wr_en;
  logic wr_ok;
  logic wr_lane;

  assign S_AXI_AWREADY = ~aw_hold & ~bvalid;
  assign S_AXI_WREADY = ~w_hold & ~bvalid;
  assign S_AXI_BVALID = bvalid;
  assign S_AXI_BRESP = bresp;
  assign wr_en = aw_hold & w_hold & ~bvalid;
  assign wr_lane = wr_en & wr_ok & w_strb[0];

  // address and data are taken in either order and held until both are in
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      aw_hold <= 1'b0;
      aw_off <= 6'h00;
      aw_hi <= 1'b0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_hold <= 1'b1;
      aw_off <= S_AXI_AWADDR[5:0];
      aw_hi <= |(S_AXI_AWADDR >> 6);
    end else if (wr_en) begin
      aw_hold <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      w_hold <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_hold <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end else if (wr_en) begin
      w_hold <= 1'b0;
    end
  end

  // decode of writable and read-only offsets
  always_comb begin
    case (aw_off)
      `IOX_OFF_IN0, `IOX_OFF_IN1, `IOX_OFF_OUT0, `IOX_OFF_OUT1,
      `IOX_OFF_POL0, `IOX_OFF_POL1, `IOX_OFF_DIR0, `IOX_OFF_DIR1,
      `IOX_OFF_BUSADR, `IOX_OFF_STAT, `IOX_OFF_MASK: begin
        wr_ok = ~aw_hi;
      end
      default: begin
        wr_ok = 1'b0;
      end
    endcase
  end

  // response follows the write one cycle later
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp <= IOX_RESP_OKAY;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      bresp <= wr_ok ? IOX_RESP_OKAY : IOX_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // writable registers

  // output latches; the pin shows them only where direction says output
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      out_reg <= {`IOX_RST_OUT, `IOX_RST_OUT}; // [R15]
    end else if (wr_lane && aw_off == `IOX_OFF_OUT0) begin
      out_reg[7:0] <= w_data[7:0]; // [R04]
    end else if (wr_lane && aw_off == `IOX_OFF_OUT1) begin
      out_reg[15:8] <= w_data[7:0]; // [R04]
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      pol <= {`IOX_RST_POL, `IOX_RST_POL}; // [R15]
    end else if (wr_lane && aw_off == `IOX_OFF_POL0) begin
      pol[7:0] <= w_data[7:0];
    end else if (wr_lane && aw_off == `IOX_OFF_POL1) begin
      pol[15:8] <= w_data[7:0];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      dir <= {`IOX_RST_DIR, `IOX_RST_DIR}; // [R03]
    end else if (wr_lane && aw_off == `IOX_OFF_DIR0) begin
      dir[7:0] <= w_data[7:0]; // [R02]
    end else if (wr_lane && aw_off == `IOX_OFF_DIR1) begin
      dir[15:8] <= w_data[7:0]; // [R02]
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      mask <= `IOX_RST_MASK;
    end else if (wr_lane && aw_off == `IOX_OFF_MASK) begin
      mask <= w_data[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  logic rvalid;
  iox_resp_t rresp;
  logic [31:0] rdata;
  logic [7:0] rd_val;
  logic rd_ok;
  logic rd_take;

  assign S_AXI_ARREADY = ~rvalid;
  assign S_AXI_RVALID = rvalid;
  assign S_AXI_RRESP = rresp;
  assign S_AXI_RDATA = rdata;
  assign rd_take = S_AXI_ARVALID & ~rvalid;

  // input offsets return live port data, not the latched copy
  always_comb begin
    rd_ok = ~|(S_AXI_ARADDR >> 6);
    case (S_AXI_ARADDR[5:0])
      `IOX_OFF_IN0: rd_val = live[7:0]; // [R10]
      `IOX_OFF_IN1: rd_val = live[15:8]; // [R10]
      `IOX_OFF_OUT0: rd_val = out_reg[7:0]; // [R06]
      `IOX_OFF_OUT1: rd_val = out_reg[15:8];
      `IOX_OFF_POL0: rd_val = pol[7:0];
      `IOX_OFF_POL1: rd_val = pol[15:8];
      `IOX_OFF_DIR0: rd_val = dir[7:0];
      `IOX_OFF_DIR1: rd_val = dir[15:8];
      `IOX_OFF_BUSADR: rd_val = {1'b0, bus_addr}; // [R09]
      `IOX_OFF_STAT: rd_val = {6'h00, stat};
      `IOX_OFF_MASK: rd_val = {6'h00, mask};
      default: begin
        rd_val = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      rvalid <= 1'b0;
      rresp <= IOX_RESP_OKAY;
      rdata <= 32'h00000000;
    end else if (rd_take) begin
      rvalid <= 1'b1;
      rresp <= rd_ok ? IOX_RESP_OKAY : IOX_RESP_SLVERR;
      rdata <= rd_ok ? {24'h000000, rd_val} : 32'h00000000;
    end else if (S_AXI_RREADY) begin
      rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input latch and change alert

  // a read latches the half it returned, which clears that half's alert
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      settle <= `IOX_SETTLE_CYCLES;
      in_reg <= 16'h0000;
    end else if (settle != 3'd0) begin
      settle <= settle - 3'd1;
      in_reg <= live; // [R15]
    end else if (rd_take && rd_ok && S_AXI_ARADDR[5:0] == `IOX_OFF_IN0) begin
      in_reg[7:0] <= live[7:0]; // [R11] [R04]
    end else if (rd_take && rd_ok && S_AXI_ARADDR[5:0] == `IOX_OFF_IN1) begin
      in_reg[15:8] <= live[15:8]; // [R11] [R04]
    end
  end

  // alert is a registered compare, so it drops one cycle after the data returns
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      ALERT_N_OE <= 1'b0;
    end else begin
      ALERT_N_OE <= |diff; // [R07] [R11]
    end
  end

  assign ALERT_N_OUT = 1'b0;

  // sticky status: a change in the clearing cycle wins over the clear
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      stat <= 2'h0;
    end else if (wr_lane && aw_off == `IOX_OFF_STAT) begin
      stat <= (stat & ~w_data[1:0]) | ev;
    end else begin
      stat <= stat | ev;
    end
  end

  assign IRQ = |(stat & mask);

  ////////////////////////////////////////////////////////////////////////////
  // port pins

  // a pin drives only where its direction bit is zero
  assign PORT_LOW_HALF_PINS_OUT = out_reg[7:0];
  assign PORT_HIGH_HALF_PINS_OUT = out_reg[15:8];
  assign PORT_LOW_HALF_PINS_OE = ~dir[7:0]; // [R02]
  assign PORT_HIGH_HALF_PINS_OE = ~dir[15:8]; // [R02]

endmodule : iox_core

// ### sim/iox_core_checker.sv
// concurrent checks on the ports of the expander core
`timescale 1ns/10ps
module iox_core_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic [7:0] PORT_LOW_HALF_PINS_OUT,
  input wire logic [7:0] PORT_LOW_HALF_PINS_OE,
  input wire logic [7:0] PORT_HIGH_HALF_PINS_OUT,
  input wire logic [7:0] PORT_HIGH_HALF_PINS_OE,
  input wire logic ALERT_N_OUT,
  input wire logic ALERT_N_OE,
  input wire logic IRQ,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  import iox_pkg::*;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  ////////////////////////////////////////////////////////////////////////////////
  // first edge after reset release must already show the defaults
  property p_oe_rst;
    $fell(SRST) |-> (PORT_LOW_HALF_PINS_OE == 8'h00 && PORT_HIGH_HALF_PINS_OE == 8'h00);
  endproperty
  a_oe_rst: assert property (p_oe_rst) else $error("pins not all inputs after reset");
  property p_out_rst;
    $fell(SRST) |-> (PORT_LOW_HALF_PINS_OUT == 8'hff && PORT_HIGH_HALF_PINS_OUT == 8'hff);
  endproperty
  a_out_rst: assert property (p_out_rst) else $error("output latch not at default");
  property p_alert_rst;
    $fell(SRST) |-> !ALERT_N_OE && !IRQ;
  endproperty
  a_alert_rst: assert property (p_alert_rst) else $error("alert active after reset");
  // open drain: the data side never drives high
  property p_alert_od;
    ALERT_N_OUT == 1'h0;
  endproperty
  a_alert_od: assert property (p_alert_od) else $error("alert data not low");
  ////////////////////////////////////////////////////////////////////////////////
  // register bus answers complete and stay well formed
  property p_b_done;
    S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write response not retired");
  property p_r_done;
    S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read response not retired");
  property p_rdata;
    S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data wider than a byte");
  property p_arready;
    S_AXI_ARREADY == !S_AXI_RVALID;
  endproperty
  a_arready: assert property (p_arready) else $error("read address ready wrong");
endmodule : iox_core_checker
bind iox_core iox_core_checker #(.ADDR_W(ADDR_W)) u_chk (.SYS_CLK, .SRST,
  .PORT_LOW_HALF_PINS_OUT, .PORT_LOW_HALF_PINS_OE, .PORT_HIGH_HALF_PINS_OUT,
  .PORT_HIGH_HALF_PINS_OE, .ALERT_N_OUT, .ALERT_N_OE, .IRQ, .S_AXI_BVALID, .S_AXI_BREADY,
  .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY);

// ### sim/iox_pin_model.sv
// pin-side load: resolves each pin from the core's drive and an outside source
`timescale 1ns/10ps
module iox_pin_model (
  input wire logic [7:0] drv_oe,
  input wire logic [7:0] drv_out,
  input wire logic [7:0] ext,
  output logic [7:0] pin
);
  // a driven pin shows the latch, a released pin whatever the outside drives
  assign pin = (drv_oe & drv_out) | (~drv_oe & ext);
endmodule : iox_pin_model

// ### sim/test_iox_core.sv
// self-checking bench for the expander core
`timescale 1ns/10ps
`include "iox_defines.svh"
module test_iox_core;
  import iox_pkg::*;
  logic sys_clk = 1'h0, srst = 1'h1, rst_pin_n = 1'h1, adr_sel = 1'h0;
  logic [7:0] ext_lo = 8'h00, ext_hi = 8'h00, pin_lo, pin_hi, out_lo, out_hi, oe_lo, oe_hi;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, alert_out, alert_oe, irq;
  iox_resp_t bresp, rresp;
  int n_fail = 0, num_checks = 0;
  logic [7:0] dflt_a [10] = '{`IOX_OFF_IN0, `IOX_OFF_IN1, `IOX_OFF_OUT0, `IOX_OFF_OUT1,
    `IOX_OFF_POL0, `IOX_OFF_POL1, `IOX_OFF_DIR0, `IOX_OFF_DIR1, `IOX_OFF_STAT, `IOX_OFF_MASK};
  logic [7:0] dflt_v [10] = '{8'h00, 8'h00, `IOX_RST_OUT, `IOX_RST_OUT, `IOX_RST_POL,
    `IOX_RST_POL, `IOX_RST_DIR, `IOX_RST_DIR, 8'h00, `IOX_RST_MASK};
  ////////////////////////////////////////////////////////////////////////////////
  iox_core dut (.SYS_CLK(sys_clk), .SRST(srst), .RESET_N_PIN(rst_pin_n), .ADDR_SEL_PIN(adr_sel),
    .PORT_LOW_HALF_PINS_IN(pin_lo), .PORT_LOW_HALF_PINS_OUT(out_lo),
    .PORT_LOW_HALF_PINS_OE(oe_lo), .PORT_HIGH_HALF_PINS_IN(pin_hi),
    .PORT_HIGH_HALF_PINS_OUT(out_hi), .PORT_HIGH_HALF_PINS_OE(oe_hi),
    .ALERT_N_OUT(alert_out), .ALERT_N_OE(alert_oe), .IRQ(irq),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  iox_pin_model u_lo (.drv_oe(oe_lo), .drv_out(out_lo), .ext(ext_lo), .pin(pin_lo));
  iox_pin_model u_hi (.drv_oe(oe_hi), .drv_out(out_hi), .ext(ext_hi), .pin(pin_hi));
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_resp(input string what, input iox_resp_t exp, input iox_resp_t got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_resp
  // ready is sampled mid-cycle: inputs only move at rising edges, so it is settled there
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input iox_resp_t er);
    int n;
    logic aw_t, w_t, b_t;
    iox_resp_t rs;
    n = 0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge sys_clk);
      aw_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = bvalid;
      rs = bresp;
      @(posedge sys_clk);
      if (aw_t) awvalid <= 1'h0;
      if (w_t) wvalid <= 1'h0;
      n++;
    end while (b_t !== 1'h1 && n < 64);
    bready <= 1'h0;
    chk("bvalid", 32'h1, b_t);
    if (b_t !== 1'h1) tally_and_finish();
    chk_resp($sformatf("bresp %h", a), er, rs);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input iox_resp_t er);
    int n;
    logic ar_t, r_t;
    logic [31:0] rv;
    iox_resp_t rs;
    n = 0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge sys_clk);
      ar_t = arvalid & arready;
      r_t = rvalid;
      rv = rdata;
      rs = rresp;
      @(posedge sys_clk);
      if (ar_t) arvalid <= 1'h0;
      n++;
    end while (r_t !== 1'h1 && n < 64);
    rready <= 1'h0;
    chk("rvalid", 32'h1, r_t);
    if (r_t !== 1'h1) tally_and_finish();
    chk($sformatf("reg %h", a), {24'h0, d}, rv);
    chk_resp($sformatf("rresp %h", a), er, rs);
  endtask : rd
  // pin changes need four edges plus one for the alert; eight leaves margin
  task automatic settle;
    repeat (8) @(negedge sys_clk);
  endtask : settle
  task automatic pins(input logic [7:0] lo, input logic [7:0] hi);
    @(posedge sys_clk);
    ext_lo <= lo;
    ext_hi <= hi;
    settle();
  endtask : pins
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge sys_clk);
    srst <= 1'h0;
    for (int i = 0; i < 10; i++) rd(dflt_a[i], dflt_v[i], IOX_RESP_OKAY);
    chk("oe", 32'h0, {oe_hi, oe_lo});
    $display("test defaults done");
    wr(`IOX_OFF_POL0, 8'h0f, IOX_RESP_OKAY);
    settle();
    chk("alert", 32'h1, alert_oe);
    rd(`IOX_OFF_IN0, 8'h0f, IOX_RESP_OKAY);
    settle();
    chk("alert", 32'h0, alert_oe);
    pins(8'h30, 8'h00);
    chk("alert", 32'h1, alert_oe);
    pins(8'h00, 8'h00);
    chk("alert", 32'h0, alert_oe);
    pins(8'h00, 8'h01);
    chk("alert", 32'h1, alert_oe);
    rd(`IOX_OFF_IN1, 8'h01, IOX_RESP_OKAY);
    settle();
    chk("alert", 32'h0, alert_oe);
    $display("test alert done");
    wr(`IOX_OFF_STAT, 8'h03, IOX_RESP_OKAY);
    wr(`IOX_OFF_MASK, 8'h01, IOX_RESP_OKAY);
    pins(8'h00, 8'h00);
    rd(`IOX_OFF_STAT, 8'h02, IOX_RESP_OKAY);
    chk("irq", 32'h0, irq);
    pins(8'h04, 8'h00);
    chk("irq", 32'h1, irq);
    pins(8'h00, 8'h00);
    wr(`IOX_OFF_STAT, 8'h03, IOX_RESP_OKAY);
    settle();
    chk("irq", 32'h0, irq);
    $display("test interrupt done");
    wr(`IOX_OFF_DIR0, 8'h00, IOX_RESP_OKAY);
    wr(`IOX_OFF_OUT0, 8'ha5, IOX_RESP_OKAY);
    rd(`IOX_OFF_IN1, 8'h00, IOX_RESP_OKAY);
    pins(8'hff, 8'h00);
    chk("oe", 32'hff, oe_lo);
    chk("pins", 32'ha5, pin_lo);
    chk("alert", 32'h0, alert_oe);
    rd(`IOX_OFF_OUT0, 8'ha5, IOX_RESP_OKAY);
    wr(`IOX_OFF_DIR1, 8'hf0, IOX_RESP_OKAY);
    wr(`IOX_OFF_OUT1, 8'h3c, IOX_RESP_OKAY);
    chk("oe_hi", 32'h0f, oe_hi);
    chk("out_hi", 32'h3c, out_hi);
    @(posedge sys_clk);
    adr_sel <= 1'h1;
    settle();
    rd(`IOX_OFF_BUSADR, {1'h0, `IOX_BUS_ADDR_BASE, 1'h1}, IOX_RESP_OKAY);
    rd(8'h2c, 8'h00, IOX_RESP_SLVERR);
    wr(8'h2c, 8'h55, IOX_RESP_SLVERR);
    $display("test outputs done");
    @(posedge sys_clk);
    rst_pin_n <= 1'h0;
    repeat (10) @(negedge sys_clk);
    chk("oe", 32'h0, {oe_hi, oe_lo});
    chk("out", 32'hff, out_lo);
    @(posedge sys_clk);
    rst_pin_n <= 1'h1;
    repeat (10) @(negedge sys_clk);
    rd(`IOX_OFF_DIR0, `IOX_RST_DIR, IOX_RESP_OKAY);
    rd(`IOX_OFF_POL0, `IOX_RST_POL, IOX_RESP_OKAY);
    chk("alert", 32'h0, alert_oe);
    rd(`IOX_OFF_IN0, 8'hff, IOX_RESP_OKAY);
    $display("test pin reset done");
    tally_and_finish();
  end
endmodule : test_iox_core
